// file: addr_ctl_checker.sv
// Timing checks on readback, wrap flag, mailbox flag, data path.
// Assumes the default widths of the bound block.
`timescale 1ns/100ps
module addr_ctl_checker #(
  parameter logic [15:0] MBOX_ADDR = 16'hFFFF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire port_ctl_pkg::cnt_ctl_t cnt_ctl,
  input wire logic addr_counter_readback_n,
  input wire logic wrap_mask_readback_n,
  input wire logic addr_oe,
  input wire logic port_select_low_n,
  input wire logic [17:0] mem_rdata,
  input wire logic [17:0] data_out,
  input wire port_ctl_pkg::peer_wr_t peer_wr,
  input wire logic counter_wrap_irq_n,
  input wire logic mailbox_irq_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Cause of a mailbox flag
  sequence mbox_hit;
    peer_wr.valid && peer_wr.addr == MBOX_ADDR;
  endsequence
  cnt_rb_a: assert property (!addr_counter_readback_n |=> addr_oe)
    else $error("counter readback not driven");
  mask_rb_a: assert property (!wrap_mask_readback_n |=> addr_oe)
    else $error("mask readback not driven");
  pins_free_a: assert property (addr_counter_readback_n &&
    wrap_mask_readback_n |=> !addr_oe) else $error("pins still driven");
  wrap_cause_a: assert property (!counter_wrap_irq_n |->
    !$past(cnt_ctl.step_n) && $past(cnt_ctl.clear_n) && $past(cnt_ctl.load_n))
    else $error("wrap flag without a step");
  wrap_end_a: assert property (!counter_wrap_irq_n &&
    cnt_ctl.step_n |=> counter_wrap_irq_n) else $error("wrap flag stuck");
  mbox_set_a: assert property (mbox_hit |=> !mailbox_irq_n)
    else $error("mailbox flag not raised");
  mbox_hold_a: assert property (!mailbox_irq_n &&
    port_select_low_n |=> !mailbox_irq_n) else $error("mailbox flag lost");
  data_pipe_a: assert property ($past(reset_n) |->
    data_out == $past(mem_rdata)) else $error("read word not delayed");
endmodule // addr_ctl_checker
bind port_addr_ctl addr_ctl_checker #(.MBOX_ADDR(MBOX_ADDR)) chk_u (.*);

// file: addr_pin_model.sv
// Master side of the shared address lines.
// Assumes addr_oe is high while the block drives them.
`timescale 1ns/100ps
module addr_pin_model (
  input wire logic [15:0] m_addr,
  input wire logic rb_any_n,
  input wire logic [15:0] addr_out,
  input wire logic addr_oe,
  output logic [15:0] pin
);
  // Master lets go in readback; a floating line never reads as old data
  assign pin = addr_oe ? addr_out : rb_any_n ? m_addr : ~m_addr;
endmodule // addr_pin_model

// file: port_addr_ctl.sv
// Per-port address counter, wrap mask, wrap flag and mailbox flag.
// Assumes the memory array sits outside; its read word comes in on mem_rdata.
// Assumes all inputs are synchronous to ref_clk; reset_n is asynchronous.
`timescale 1ns/100ps
`include "port_ctl_map.svh"

module port_addr_ctl #(
  // Widths and the mailbox cell owned by this port
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W,
  parameter logic [`ADDR_W-1:0] MBOX_ADDR = `MBOX_DEFAULT_ADDR
) (
  // Clock and master reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Counter and mask controls, all active low
  input wire port_ctl_pkg::cnt_ctl_t cnt_ctl,
  input wire logic addr_counter_readback_n,
  input wire logic wrap_mask_readback_n,
  // Address pins: value seen, value driven and its enable
  input wire logic [ADDR_W-1:0] addr_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe,
  // Port selects and read controls
  input wire logic port_select_low_n,
  input wire logic port_select_high,
  input wire logic read_not_write,
  input wire logic lower_half_select_n,
  input wire logic upper_half_select_n,
  input wire logic output_enable_n,
  // Read word of the array and the data pins
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic [DATA_W-1:0] data_out,
  output logic [1:0] data_oe,
  // Writes by the other ports and the two flags
  input wire port_ctl_pkg::peer_wr_t peer_wr,
  output logic counter_wrap_irq_n,
  output logic mailbox_irq_n
);

  // Counter, mask and decode signals
  logic [ADDR_W-1:0] count_r;
  logic [ADDR_W-1:0] count_nxt;
  logic [ADDR_W-1:0] mask_r;
  logic wrap_now;
  logic port_on;
  logic own_read;
  logic peer_hit;
  port_ctl_pkg::aout_sel_t aout_sel;

  // Masked step: unmasked bits count, masked bits hold their value
  // Forcing held bits to one lets the carry ripple straight past them
  function automatic logic [ADDR_W-1:0] masked_step(
    input logic [ADDR_W-1:0] cur,
    input logic [ADDR_W-1:0] msk
  );
    logic [ADDR_W-1:0] filled;
    logic [ADDR_W-1:0] bumped;
    filled = cur | ~msk;
    bumped = filled + ADDR_W'(1);
    masked_step = (bumped & msk) | (cur & ~msk);
  endfunction

  // Wrap happens when all unmasked bits are already one
  // A mask of zero makes every step a wrap, so each step pulls the flag low
  function automatic logic at_top(
    input logic [ADDR_W-1:0] cur,
    input logic [ADDR_W-1:0] msk
  );
    at_top = ((cur & msk) == msk);
  endfunction

  // Drive decode for one data half: selected, reading, enabled
  function automatic logic half_drive(
    input logic on,
    input logic rd,
    input logic oe_n,
    input logic half_n
  );
    half_drive = on && rd && !oe_n && !half_n;
  endfunction

  // Port active only with both selects asserted
  // Either select off keeps reads and mailbox clears away
  assign port_on = !port_select_low_n && port_select_high;
  // Own read takes the counter as its address; the array path is outside
  assign own_read = port_on && read_not_write && (count_r == MBOX_ADDR);
  // Write into our cell by another port
  assign peer_hit = peer_wr.valid && (peer_wr.addr == MBOX_ADDR);

  // Next counter value, clear beats load beats step
  // Mask load is separate and may share the cycle with any of these
  always_comb begin
    count_nxt = count_r;
    wrap_now = 1'b0;
    if (!cnt_ctl.clear_n) begin
      count_nxt = `CNT_RESET_VAL;
    end else if (!cnt_ctl.load_n) begin
      count_nxt = addr_in;
    end else if (!cnt_ctl.step_n) begin
      count_nxt = masked_step(count_r, mask_r);
      wrap_now = at_top(count_r, mask_r);
    end
  end

  // Address counter
  // Reset and clear share one value, so both start from the bottom
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= `CNT_RESET_VAL;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Wrap mask register; all ones means unmasked
  // A new mask steers the first step after the edge that loads it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= `MASK_RESET_VAL;
    end else if (!cnt_ctl.mask_load_n) begin
      mask_r <= addr_in;
    end
  end

  // Wrap flag: registered, so it lasts one cycle unless wrapping again
  // Back-to-back wraps keep it low; no stretch logic is needed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_wrap_irq_n <= `IRQ_IDLE;
    end else begin
      counter_wrap_irq_n <= !wrap_now;
    end
  end

  // Mailbox flag; a peer write in the clearing cycle wins
  // Set before clear, so a message sent during the read is not lost
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mailbox_irq_n <= `IRQ_IDLE;
    end else if (peer_hit) begin
      mailbox_irq_n <= 1'b0;
    end else if (own_read) begin
      mailbox_irq_n <= `IRQ_IDLE;
    end
  end

  // Address pin source; counter readback has precedence over mask
  // Chip enables are not consulted, so readback works unselected
  always_comb begin
    if (!addr_counter_readback_n) begin
      aout_sel = port_ctl_pkg::AOUT_CNT;
    end else if (!wrap_mask_readback_n) begin
      aout_sel = port_ctl_pkg::AOUT_MASK;
    end else begin
      aout_sel = port_ctl_pkg::AOUT_NONE;
    end
  end

  // Address pins registered; the master has released them meanwhile
  // Holding the last value when idle keeps the outputs from toggling
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_out <= `ADDR_OUT_RESET_VAL;
      addr_oe <= `OE_OFF;
    end else begin
      unique case (aout_sel)
        port_ctl_pkg::AOUT_CNT: begin
          addr_out <= count_r;
          addr_oe <= 1'b1;
        end
        port_ctl_pkg::AOUT_MASK: begin
          addr_out <= mask_r;
          addr_oe <= 1'b1;
        end
        port_ctl_pkg::AOUT_NONE: begin
          addr_out <= addr_out;
          addr_oe <= 1'b0;
        end
      endcase
    end
  end

  // Data word from the array, mailbox cell included as plain storage
  // One register stage matches the pipelined read of the array
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= `DATA_ZERO;
    end else begin
      data_out <= mem_rdata;
    end
  end

  // Data enables need both selects, a read, and each half select
  // Output enable is asynchronous at the pins, so these stay combinational
  assign data_oe[`LO_HALF] = half_drive(port_on, read_not_write,
    output_enable_n, lower_half_select_n);
  assign data_oe[`HI_HALF] = half_drive(port_on, read_not_write,
    output_enable_n, upper_half_select_n);

endmodule // port_addr_ctl

// file: port_ctl_map.svh
// Constants for the per-port counter, mask and mailbox logic.
// Assumes a 16-bit address and an 18-bit data word.
`ifndef PORT_CTL_MAP_SVH
`define PORT_CTL_MAP_SVH
`define ADDR_W 16
`define DATA_W 18
`define CNT_RESET_VAL 16'h0000
`define MASK_RESET_VAL 16'hFFFF
`define MBOX_DEFAULT_ADDR 16'hFFFF
`define DATA_ZERO 18'h0_0000
`define ADDR_OUT_RESET_VAL 16'h0000
`define IRQ_IDLE 1'h1
`define OE_OFF 1'h0
`define LO_HALF 0
`define HI_HALF 1
`endif

// file: port_ctl_pkg.sv
// Types shared by the per-port control block.
// Assumes port_ctl_map.svh is on the include path.
`include "port_ctl_map.svh"
package port_ctl_pkg;
  // Counter control strobes of one port, all active low
  typedef struct packed {
    logic clear_n;
    logic load_n;
    logic step_n;
    logic mask_load_n;
  } cnt_ctl_t;
  // Write seen on another port of the array
  typedef struct packed {
    logic valid;
    logic [`ADDR_W-1:0] addr;
  } peer_wr_t;
  // Which value drives the address pins
  typedef enum logic [2:0] {
    AOUT_NONE = 3'b001,
    AOUT_CNT = 3'b010,
    AOUT_MASK = 3'b100
  } aout_sel_t;
endpackage

// file: testbench.sv
// Scenarios for the port counter, mask and mailbox flag.
// Assumes package, pin model and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 0, reset_n = 0, crb_n = 1, mrb_n = 1, sl_n = 1, sh = 0;
  logic oe_n = 1, lhs_n = 0, uhs_n = 0, rnw = 1, addr_oe, wrap_n, mbox_n;
  logic [15:0] m_addr = 0, pin, a_out;
  logic [17:0] rdata = 0, d_out;
  logic [1:0] d_oe;
  port_ctl_pkg::cnt_ctl_t ctl = '1;
  port_ctl_pkg::peer_wr_t pw = '0;
  int err_count = 0, compares = 0;
  port_addr_ctl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .cnt_ctl(ctl),
    .addr_counter_readback_n(crb_n), .wrap_mask_readback_n(mrb_n),
    .addr_in(pin), .addr_out(a_out), .addr_oe(addr_oe),
    .port_select_low_n(sl_n), .port_select_high(sh), .read_not_write(rnw),
    .lower_half_select_n(lhs_n), .upper_half_select_n(uhs_n),
    .output_enable_n(oe_n), .mem_rdata(rdata), .data_out(d_out),
    .data_oe(d_oe), .peer_wr(pw), .counter_wrap_irq_n(wrap_n),
    .mailbox_irq_n(mbox_n));
  addr_pin_model pin_u (.m_addr(m_addr), .rb_any_n(crb_n & mrb_n),
    .addr_out(a_out), .addr_oe(addr_oe), .pin(pin));
  // Clock
  initial forever #4 ref_clk = ~ref_clk;
  task chk(input string n, input logic [17:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  // Strobe held n edges; pins carry a meanwhile
  task put(input logic [3:0] c, input logic [15:0] a, input int n);
    @(posedge ref_clk);
    ctl <= c;
    m_addr <= a;
    repeat (n) @(posedge ref_clk);
    ctl <= '1;
  endtask
  // Readback takes one edge to turn the pins round
  task rb(input logic cnt, input logic [15:0] e);
    @(posedge ref_clk);
    crb_n <= !cnt;
    mrb_n <= cnt;
    @(posedge ref_clk) #1;
    chk("addr pins", 18'(a_out), 18'(e));
    chk("addr oe", 18'(addr_oe), 18'h0_0001);
    @(posedge ref_clk);
    crb_n <= 1;
    mrb_n <= 1;
  endtask
  task t_count;
    rb(1, 16'h0000);
    rb(0, 16'hFFFF);
    put(4'b1011, 16'h1234, 1);
    put(4'b1101, 16'h0000, 3);
    rb(1, 16'h1237);
    put(4'b0011, 16'h5555, 1);
    rb(1, 16'h0000);
    put(4'b1001, 16'h0100, 1);
    rb(1, 16'h0100);
  endtask
  // Low nibble counts, upper bits held across the wrap
  task t_wrap;
    put(4'b1110, 16'h000F, 1);
    rb(0, 16'h000F);
    put(4'b1011, 16'h00AE, 1);
    put(4'b1101, 16'h0000, 1);
    #1 chk("wrap irq", 18'(wrap_n), 18'h0_0001);
    put(4'b1101, 16'h0000, 1);
    #1 chk("wrap irq", 18'(wrap_n), 18'h0_0000);
    @(posedge ref_clk) #1 chk("wrap irq", 18'(wrap_n), 18'h0_0001);
    rb(1, 16'h00A0);
  endtask
  task t_mbox;
    @(posedge ref_clk);
    pw <= '{1'b1, 16'h0001};
    @(posedge ref_clk);
    pw <= '{1'b1, 16'hFFFF};
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0001);
    @(posedge ref_clk);
    pw <= '0;
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0000);
    put(4'b1011, 16'hFFFF, 1);
    sl_n <= 0;
    sh <= 1;
    oe_n <= 0;
    rnw <= 0;
    rdata <= 18'h2_5A5A;
    #1 chk("data oe", 18'(d_oe), 18'h0_0000);
    @(posedge ref_clk);
    rnw <= 1;
    pw <= '{1'b1, 16'hFFFF};
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0000);
    chk("data oe", 18'(d_oe), 18'h0_0003);
    @(posedge ref_clk);
    pw <= '0;
    uhs_n <= 1;
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0000);
    chk("data oe", 18'(d_oe), 18'h0_0001);
    @(posedge ref_clk);
    {sl_n, sh} <= 2'b00;
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0001);
    chk("data", d_out, 18'h2_5A5A);
    chk("data oe", 18'(d_oe), 18'h0_0000);
    @(posedge ref_clk);
    {sl_n, oe_n, uhs_n} <= 3'b110;
  endtask
  // Mid-run reset with the flag up and a narrowed mask
  task t_reset;
    put(4'b1110, 16'h00F0, 1);
    @(posedge ref_clk);
    pw <= '{1'b1, 16'hFFFF};
    @(posedge ref_clk);
    pw <= '0;
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0000);
    @(posedge ref_clk);
    reset_n <= 0;
    #1 chk("mbox irq", 18'(mbox_n), 18'h0_0001);
    chk("data", d_out, 18'h0_0000);
    repeat (2) @(posedge ref_clk);
    reset_n <= 1;
    rb(1, 16'h0000);
    rb(0, 16'hFFFF);
  endtask
  task final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1;
    t_count;
    t_wrap;
    t_mbox;
    t_reset;
    final_report;
  end
endmodule // testbench
